/* File: inc/tdb_map.svh */
/*
 * register offsets, field positions, reset values and timing counts for the
 * timer dead-time / brake / repetition / adc trigger block.
 * assumes: included by bare name from the package only; the design files use its macros.
 */
`ifndef TDB_MAP_SVH
`define TDB_MAP_SVH

// ***********************************************
// register offsets
// ***********************************************
`define TDB_OFF_TRIG 8'h20
`define TDB_OFF_DTR 8'h30
`define TDB_OFF_RCR 8'h34

// ***********************************************
// reset values and writable masks
// ***********************************************
`define TDB_RST_TRIG 32'h0000_0000
`define TDB_RST_DTR 32'h0000_0000
`define TDB_RST_RCR 32'h0000_0000
`define TDB_MASK_TRIG 32'h0000_00ff
`define TDB_MASK_DTR 32'h0000_7eff
`define TDB_MASK_RCR 32'h0000_03ff

// ***********************************************
// field positions
// ***********************************************
`define TDB_TRIG_GATE 7
`define TDB_TRIG_UPD 0
`define TDB_DTR_CMP 14
`define TDB_DTR_SAFE 13
`define TDB_DTR_MOE 12
`define TDB_DTR_AOE 11
`define TDB_DTR_BKE 10
`define TDB_DTR_DEAD_TIME_INSERT_EN 9
`define TDB_RCR_UD 9
`define TDB_RCR_OV 8

// ***********************************************
// dead-time decode constants
// ***********************************************
`define TDB_DT_BASE 2
`define TDB_DT_OFF1 64
`define TDB_DT_OFF2 32

`endif

/* File: inc/tdb_pkg.sv */
/*
 * types shared by the block: register image and pwm pin bundle.
 * assumes: tdb_map.svh is on the include path.
 */
package tdb_pkg;
    `include "tdb_map.svh"

    // three software registers
    typedef struct packed {
        logic [31:0] trig;
        logic [31:0] dtr;
        logic [31:0] repeat_reload_value;
    } tdb_regs_s;

    // three complementary pin pairs: value and enable
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
        logic [2:0] pos_oe;
        logic [2:0] neg_oe;
    } tdb_pins_s;

    // dead-time inserter phase
    typedef enum logic [1:0] {
        DT_IDLE,
        DT_WAIT,
        DT_DONE
    } tdb_dt_e;
endpackage : tdb_pkg

/* File: core/tdb_deadtime.sv */
/*
 * one complementary output pair with dead-time insertion.
 * assumes: ref_in is the raw pwm reference from the compare logic, same clock.
 */
`timescale 1ns/1ps
module tdb_deadtime (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // control
    input wire logic dt_en,
    input wire logic [10:0] dt_len,
    input wire logic ref_in,
    // pair out
    output logic pos_out,
    output logic neg_out
);
    import tdb_pkg::*;

    // ***********************************************
    // state
    // ***********************************************
    typedef struct packed {
        logic ref_q;
        logic [10:0] cnt;
        logic pos;
        logic neg;
        tdb_dt_e ph;
    } tdb_dts_s;

    tdb_dts_s s_q;
    tdb_dts_s s_d;

    // next state: on each reference edge both sides stay low for dt_len plus one cycles
    always_comb begin
        s_d = s_q;
        s_d.ref_q = ref_in;
        if (!dt_en) begin
            // no dead time: plain complementary copy
            s_d.pos = ref_in;
            s_d.neg = ~ref_in;
            s_d.ph = DT_IDLE;
        end else if (ref_in != s_q.ref_q) begin
            // edge: both off and start the gap
            s_d.pos = 1'b0;
            s_d.neg = 1'b0;
            s_d.cnt = dt_len;
            s_d.ph = DT_WAIT;
        end else begin
            case (s_q.ph)
                DT_WAIT: begin
                    if (s_q.cnt <= 11'h001) begin
                        s_d.ph = DT_DONE;
                    end else begin
                        s_d.cnt = s_q.cnt - 11'h001;
                    end
                end
                DT_DONE, DT_IDLE: begin
                    s_d.pos = ref_in;
                    s_d.neg = ~ref_in;
                    s_d.ph = DT_IDLE;
                end
                default: s_d.ph = DT_IDLE;
            endcase
        end
    end

    // register the state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '{ref_q: 1'b0, cnt: 11'h000, pos: 1'b0, neg: 1'b1, ph: DT_IDLE};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign pos_out = s_q.pos;
    assign neg_out = s_q.neg;
endmodule : tdb_deadtime

/* File: core/tdb_top.sv */
/*
 * adc trigger selection, brake / output enable, dead-time and repetition
 * counter of an advanced timer.
 * assumes: match and wrap strobes come from the timer on clk_sys;
 * brake sources are asynchronous pins.
 */
`timescale 1ns/1ps
// Function
// - global gate bit 7 blocks all triggers
// - six compare matches trigger when individually enabled
// - bit 0 makes update event trigger adc
// - bit 14 lets comparator brake outputs
// - bit 13 enables safety brake sources
// - pins driven only while bit 12 set
// - bit 11 re-enables outputs automatically
// - brake inputs act only with bit 10
// - bit 9 inserts dead time
// - dead-time decode for 0x and 10 codes
// - dead-time decode for 110 and 111 codes
// - bit 9 masks underflows from repeat count
// - bit 8 masks overflows from repeat count
// - update every repeat value plus one wraps
// - unmasked wrap decrements repeat counter
// - zero reloads counter and fires update
module tdb_top (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // timer events
    input wire logic [5:0] cmp_match,
    input wire logic cnt_overflow,
    input wire logic cnt_underflow,
    input wire logic [2:0] pwm_ref,
    // brake sources (asynchronous)
    input wire logic brake_pin,
    input wire logic comparator_out,
    input wire logic safety_fault,
    // outputs
    output logic adc_trigger,
    output logic update_event_signal,
    output tdb_pkg::tdb_pins_s pins
);
    import tdb_pkg::*;

    // ***********************************************
    // state
    // ***********************************************
    typedef struct packed {
        tdb_regs_s regs;
        logic [7:0] repeat_down_counter;
        logic [2:0] bk_pin;
        logic [2:0] bk_cmp;
        logic [2:0] bk_safe;
        logic brake_prev;
        logic adc_trig;
        logic upd;
        logic [31:0] rdata;
    } tdb_state_s;

    tdb_state_s s_q;
    tdb_state_s s_d;

    logic [2:0] dt_pos;
    logic [2:0] dt_neg;

    // dead-time length in clocks from the 8-bit code
    function automatic logic [10:0] dt_decode(input logic [7:0] c);
        logic [10:0] t;
        t = 11'h000;
        if (!c[7]) begin
            t = {4'h0, c[6:0]} + 11'(`TDB_DT_BASE);
        end else if (!c[6]) begin
            t = (({5'h00, c[5:0]} + 11'(`TDB_DT_OFF1)) << 1) + 11'(`TDB_DT_BASE);
        end else if (!c[5]) begin
            t = (({6'h00, c[4:0]} + 11'(`TDB_DT_OFF2)) << 3) + 11'(`TDB_DT_BASE);
        end else begin
            t = (({6'h00, c[4:0]} + 11'(`TDB_DT_OFF2)) << 4) + 11'(`TDB_DT_BASE);
        end
        return t;
    endfunction : dt_decode

    // brake line agreed high by 2nd and 3rd synchroniser stages
    function automatic logic sync_hi(input logic [2:0] sr);
        return sr[1] & sr[2];
    endfunction : sync_hi

    // brake line agreed low by 2nd and 3rd synchroniser stages
    function automatic logic sync_lo(input logic [2:0] sr);
        return ~sr[1] & ~sr[2];
    endfunction : sync_lo

    // ***********************************************
    // next-state logic
    // ***********************************************
    logic brake_now; // filtered brake level this cycle
    logic brake_hi; // some enabled source agreed high
    logic brake_lo; // every enabled source agreed low
    logic wrap_count; // unmasked wrap seen this cycle
    // a pin glitch that reaches only one stage must not
    // toggle the brake: the level moves only on agreement
    always_comb begin
        s_d = s_q;
        brake_now = 1'b0;
        brake_hi = 1'b0;
        brake_lo = 1'b1;
        wrap_count = 1'b0;
        // synchronisers: stage 0 is read only by stage 1
        s_d.bk_pin = {s_q.bk_pin[1:0], brake_pin};
        s_d.bk_cmp = {s_q.bk_cmp[1:0], comparator_out};
        s_d.bk_safe = {s_q.bk_safe[1:0], safety_fault};

        // register writes; reserved bits stay zero
        if (reg_wr) begin
            case (reg_addr)
                `TDB_OFF_TRIG: s_d.regs.trig = reg_wdata & `TDB_MASK_TRIG;
                `TDB_OFF_DTR: s_d.regs.dtr = reg_wdata & `TDB_MASK_DTR;
                `TDB_OFF_RCR: s_d.regs.repeat_reload_value = reg_wdata & `TDB_MASK_RCR;
                default: ;
            endcase
        end

        // register reads, data one cycle later; unmapped reads zero
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `TDB_OFF_TRIG: s_d.rdata = s_q.regs.trig;
                `TDB_OFF_DTR: s_d.rdata = s_q.regs.dtr;
                `TDB_OFF_RCR: s_d.rdata = s_q.regs.repeat_reload_value;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // brake: only with bke; comparator and safety each gated
        if (s_q.regs.dtr[`TDB_DTR_BKE]) begin
            brake_hi = sync_hi(s_q.bk_pin)
                | (s_q.regs.dtr[`TDB_DTR_CMP] & sync_hi(s_q.bk_cmp))
                | (s_q.regs.dtr[`TDB_DTR_SAFE] & sync_hi(s_q.bk_safe));
            brake_lo = sync_lo(s_q.bk_pin)
                & (~s_q.regs.dtr[`TDB_DTR_CMP] | sync_lo(s_q.bk_cmp))
                & (~s_q.regs.dtr[`TDB_DTR_SAFE] | sync_lo(s_q.bk_safe));
        end
        // hold the last level while a stage pair still disagrees
        if (brake_hi) begin
            // a source is firmly active
            brake_now = 1'b1;
        end else if (brake_lo) begin
            // all sources firmly idle, or brake disabled
            brake_now = 1'b0;
        end else begin
            // in transit: keep what was decided before
            brake_now = s_q.brake_prev;
        end
        s_d.brake_prev = brake_now;
        if (brake_now) begin
            // brake wins over a software set of main enable
            s_d.regs.dtr[`TDB_DTR_MOE] = 1'b0;
        end else if (s_q.regs.dtr[`TDB_DTR_AOE] && s_q.upd) begin
            // auto re-enable on the next update once brake is gone
            s_d.regs.dtr[`TDB_DTR_MOE] = 1'b1;
        end

        // repetition counter
        wrap_count = (cnt_overflow & ~s_q.regs.repeat_reload_value[`TDB_RCR_OV])
            | (cnt_underflow & ~s_q.regs.repeat_reload_value[`TDB_RCR_UD]);
        s_d.upd = 1'b0;
        if (wrap_count) begin
            if (s_q.repeat_down_counter == 8'h00) begin
                // reload and fire update: one per value+1 wraps
                s_d.repeat_down_counter = s_q.regs.repeat_reload_value[7:0];
                s_d.upd = 1'b1;
            end else begin
                s_d.repeat_down_counter = s_q.repeat_down_counter - 8'h01;
            end
        end

        // adc trigger: or of enabled sources, gated globally
        s_d.adc_trig = s_q.regs.trig[`TDB_TRIG_GATE]
            & ((|(cmp_match & s_q.regs.trig[6:1]))
            | (s_q.upd & s_q.regs.trig[`TDB_TRIG_UPD]));
    end

    // ***********************************************
    // state register
    // ***********************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
            s_q.regs.trig <= `TDB_RST_TRIG;
            s_q.regs.dtr <= `TDB_RST_DTR;
            s_q.regs.repeat_reload_value <= `TDB_RST_RCR;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ***********************************************
    // dead-time pairs
    // ***********************************************
    for (genvar i = 0; i < 3; i++) begin : g_dt
        tdb_deadtime u_dt (
            .clk_sys(clk_sys),
            .rst(rst),
            .ce(ce),
            .dt_en(s_q.regs.dtr[`TDB_DTR_DEAD_TIME_INSERT_EN]),
            .ref_in(pwm_ref[i]),
            .dt_len(dt_decode(s_q.regs.dtr[7:0])),
            .pos_out(dt_pos[i]),
            .neg_out(dt_neg[i])
        );
    end

    // ***********************************************
    // outputs
    // ***********************************************
    // every output comes straight from a flip-flop, so the
    // timer and the adc see glitch-free one-cycle pulses
    assign reg_rdata = s_q.rdata;
    assign adc_trigger = s_q.adc_trig;
    assign update_event_signal = s_q.upd;
    // pins driven only while main enable is set
    assign pins.pos = dt_pos;
    assign pins.neg = dt_neg;
    assign pins.pos_oe = {3{s_q.regs.dtr[`TDB_DTR_MOE]}};
    assign pins.neg_oe = {3{s_q.regs.dtr[`TDB_DTR_MOE]}};
endmodule : tdb_top

/* File: bench/tdb_top_asserts.sv */
/* checker: trigger, output enable and repeat relations at the block ports.
   assumes: bound into tdb_top, one clock domain. */
`timescale 1ns/1ps
module tdb_top_chk (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // register writes
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // timer events and brake
    input wire logic [5:0] cmp_match,
    input wire logic cnt_overflow,
    input wire logic cnt_underflow,
    input wire logic brake_pin,
    // block outputs
    input wire logic adc_trigger,
    input wire logic update_event_signal,
    input wire tdb_pkg::tdb_pins_s pins
);
    import tdb_pkg::*;
    logic [7:0] trg_q; // trigger select shadow
    logic bke_q; // brake enable shadow
    logic [9:0] rcr_q; // repeat config shadow
    logic [7:0] rep_q; // repeat counter mirror
    wire wrap_ok = cnt_overflow && !rcr_q[8] || cnt_underflow && !rcr_q[9];
    wire trig_src = trg_q[7] && (|(cmp_match & trg_q[6:1]) || trg_q[0] && update_event_signal);
    // shadow the writes and mirror the repeat count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trg_q <= 8'h00;
            bke_q <= 1'b0;
            rcr_q <= 10'h000;
            rep_q <= 8'h00;
        end else if (ce) begin
            if (reg_wr && reg_addr == 8'h20) trg_q <= reg_wdata[7:0];
            if (reg_wr && reg_addr == 8'h30) bke_q <= reg_wdata[10];
            if (reg_wr && reg_addr == 8'h34) rcr_q <= reg_wdata[9:0];
            if (wrap_ok) rep_q <= (rep_q == 8'h00) ? rcr_q[7:0] : rep_q - 8'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_gate_blocks: assert property (!trg_q[7] |=> !adc_trigger) else $error("trigger with gate off");
    a_match_trig: assert property (trg_q[7] && |(cmp_match & trg_q[6:1]) |=> adc_trigger)
        else $error("enabled match gave no trigger");
    a_update_trig: assert property (trg_q[7] && trg_q[0] && update_event_signal |=> adc_trigger)
        else $error("update gave no trigger");
    a_trig_cause: assert property (adc_trigger |-> $past(trig_src)) else $error("trigger without source");
    a_moe_off: assert property (reg_wr && reg_addr == 8'h30 && !reg_wdata[12] && !reg_wdata[11]
        |-> ##2 (pins.pos_oe == 3'h0 && pins.neg_oe == 3'h0)) else $error("outputs on after enable cleared");
    a_brake_off: assert property ((brake_pin && bke_q)[*8] |=> pins.pos_oe == 3'h0)
        else $error("brake left outputs on");
    a_rep_fire: assert property (wrap_ok && rep_q == 8'h00 |=> update_event_signal)
        else $error("no update at zero count");
    a_rep_hold: assert property (wrap_ok && rep_q != 8'h00 |=> !update_event_signal)
        else $error("update before count ran out");
    a_upd_cause: assert property (update_event_signal |-> $past(wrap_ok))
        else $error("update without counted wrap");
endmodule : tdb_top_chk
bind tdb_top tdb_top_chk u_chk (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .cmp_match,
    .cnt_overflow, .cnt_underflow, .brake_pin, .adc_trigger, .update_event_signal, .pins);

/* File: bench/tdb_stage.sv */
/* far side: an adc counting conversion starts and a power stage counting
   cycles with both switches of a pair driven on.
   assumes: same clock as the block. */
`timescale 1ns/1ps
module tdb_stage (
    // clock and pins
    input wire logic clk_sys,
    input wire tdb_pkg::tdb_pins_s pins,
    // adc start
    input wire logic adc_trigger,
    // counts seen
    output int n_conv,
    output int n_shoot
);
    import tdb_pkg::*;
    initial n_conv = 0;
    initial n_shoot = 0;
    // one conversion per trigger cycle; both switches on is a short
    always @(posedge clk_sys) begin
        if (adc_trigger === 1'b1) n_conv <= n_conv + 1;
        if (|(pins.pos & pins.neg & pins.pos_oe & pins.neg_oe)) n_shoot <= n_shoot + 1;
    end
endmodule : tdb_stage

/* File: bench/tdb_top_test.sv */
/* bench: register, trigger, repeat, brake and dead-time sequences.
   assumes: ce held high, tdb_stage stands at the far side. */
`timescale 1ns/1ps
module tdb_top_test;
    import tdb_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] evt = 8'h00; // matches, overflow, underflow
    logic [2:0] pwm_ref = 3'h0;
    logic [2:0] brk = 3'h0; // safety, comparator, pin
    logic [31:0] reg_rdata;
    logic adc_trigger;
    logic update_event_signal;
    tdb_pins_s pins;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int n_upd = 0;
    int n_conv, n_shoot, base, n, t;
    logic [7:0] offs[3] = '{8'h20, 8'h30, 8'h34};
    logic [31:0] wmask[3] = '{32'hff, 32'h7eff, 32'h3ff};
    // dtr value, brake sources, outputs expected off
    logic [19:0] btab[7] = '{20'h00001, 20'h10002, 20'h14004, 20'h54005, 20'h14008, 20'h34009, 20'h14003};
    logic [8:0] dtab[5] = '{9'h105, 9'h1bf, 9'h1c0, 9'h1ff, 9'h0ff}; // enable, code
    tdb_top dut (.clk_sys, .rst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cmp_match(evt[7:2]), .cnt_overflow(evt[1]), .cnt_underflow(evt[0]), .pwm_ref,
        .brake_pin(brk[0]), .comparator_out(brk[1]), .safety_fault(brk[2]), .adc_trigger,
        .update_event_signal, .pins);
    tdb_stage stage (.clk_sys, .pins, .adc_trigger, .n_conv, .n_shoot);
    initial forever #25 clk_sys = ~clk_sys;
    // cycle ceiling and update pulse count
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (update_event_signal === 1'b1) n_upd <= n_upd + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask : rd
    // one-cycle event pulse
    task automatic ev(input logic [7:0] v);
        @(posedge clk_sys);
        evt <= v;
        @(posedge clk_sys);
        evt <= 8'h00;
    endtask : ev
    // expected dead-time length from the four code ranges
    function automatic int dt_len(input logic [8:0] e);
        if (!e[8]) return 0;
        casez (e[7:5])
            3'b0??: return e[6:0] + 2;
            3'b10?: return (e[5:0] + 64) * 2 + 2;
            3'b110: return (e[4:0] + 32) * 8 + 2;
            default: return (e[4:0] + 32) * 16 + 2;
        endcase
    endfunction : dt_len
    task automatic test_done;
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (offs[i]) begin
            rd(offs[i], 32'h0, "reset value");
            wr(offs[i], 32'hffff_ffff);
            rd(offs[i], wmask[i], "writable bits");
            wr(offs[i], 32'h0);
        end
        rd(8'h24, 32'h0, "unmapped");
        // each match source alone, others ignored
        for (int i = 0; i < 6; i++) begin
            wr(8'h20, 32'h80 | (32'h2 << i));
            base = n_conv;
            ev({~(6'h01 << i), 2'b00});
            ev({6'h01 << i, 2'b00});
            repeat (3) @(posedge clk_sys);
            chk("match triggers", 1, n_conv - base);
        end
        wr(8'h20, 32'h7f);
        base = n_conv;
        ev(8'hfc);
        repeat (3) @(posedge clk_sys);
        chk("gated triggers", 0, n_conv - base);
        // repeat counting with masks, update drives the adc
        wr(8'h20, 32'h81);
        wr(8'h34, 32'h002);
        base = n_conv;
        n = n_upd;
        repeat (4) ev(8'h02);
        repeat (3) @(posedge clk_sys);
        chk("updates", 2, n_upd - n);
        wr(8'h34, 32'h102);
        repeat (5) ev(8'h02);
        repeat (3) ev(8'h01);
        repeat (3) @(posedge clk_sys);
        chk("updates", 3, n_upd - n);
        wr(8'h34, 32'h202);
        repeat (3) ev(8'h01);
        repeat (3) ev(8'h02);
        repeat (3) @(posedge clk_sys);
        chk("updates", 4, n_upd - n);
        chk("update triggers", 4, n_conv - base);
        // brake sources against their enables
        foreach (btab[k]) begin
            wr(8'h30, {16'h0, btab[k][19:4]});
            repeat (3) @(posedge clk_sys);
            brk <= btab[k][3:1];
            repeat (10) @(posedge clk_sys);
            chk("output enable", btab[k][0] ? 32'h0 : 32'h3f, {26'h0, pins.pos_oe, pins.neg_oe});
            brk <= 3'h0;
            repeat (4) @(posedge clk_sys);
        end
        rd(8'h30, 32'h400, "enable after brake");
        // automatic re-enable waits for an update
        wr(8'h30, 32'h1c00);
        wr(8'h34, 32'h0);
        brk <= 3'h1;
        repeat (10) @(posedge clk_sys);
        brk <= 3'h0;
        repeat (6) @(posedge clk_sys);
        chk("oe before update", 0, {29'h0, pins.pos_oe});
        repeat (3) ev(8'h02);
        repeat (4) @(posedge clk_sys);
        chk("oe after update", 32'h7, {29'h0, pins.pos_oe});
        // dead-time length per code range, and off
        foreach (dtab[k]) begin
            wr(8'h30, {19'h0, 3'h4, dtab[k][8], 1'b0, dtab[k][7:0]});
            pwm_ref <= 3'h0;
            t = dt_len(dtab[k]);
            repeat (1100) @(posedge clk_sys);
            chk("neg idle", 1, pins.neg[0]);
            pwm_ref <= 3'h7;
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (pins.pos[0] !== 1'b1 && n < 1100);
            chk("dead time", 1, n + 1 >= t && n <= t + 4);
        end
        chk("shoot through", 0, n_shoot);
        test_done;
    end
endmodule : tdb_top_test
